/* core/ftcp_pkg.sv */
package ftcp_pkg;
	// Clock and internal timebase
	localparam int CLK_PERIOD_NS = 50;
	localparam int TICK_PERIOD_NS = 1000;
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int PRE_W = 5;
	localparam int TCNT_W = 12;

	// Durations in microseconds, compare values chosen inside each window
	localparam int F3_DET_US = 30;
	localparam int F3_REC_US = 160;
	localparam int F6_DET_US = 200;
	localparam int F6_REC_US = 200;
	localparam int F47_DET_US = 1500;
	localparam int F47_REC_US = 30;
	localparam int F3A8_DET_US = 1700;
	localparam int F3A8_REC_US = 1500;
	localparam int TXD_DIS_US = 1500;
	localparam int TXD_ENA_US = 30;
	localparam int WAKE_US = 16;
	// Durations with the termination tied to battery
	localparam int VB_F47_DET_US = 1200;
	localparam int VB_F47_REC_US = 1920;
	localparam int VB_F3_DET_US = 3840;
	localparam int VB_F3_REC_US = 1920;
	localparam int VB_F3A8_DET_US = 2300;
	localparam int VB_F3A8_REC_US = 1200;

	function automatic logic [TCNT_W-1:0] ticks(input int us);
		ticks = TCNT_W'((us * 1000 + TICK_PERIOD_NS - 1) / TICK_PERIOD_NS);
	endfunction

	localparam logic [TCNT_W-1:0] F3_DET_T = ticks(F3_DET_US);
	localparam logic [TCNT_W-1:0] F3_REC_T = ticks(F3_REC_US);
	localparam logic [TCNT_W-1:0] F6_DET_T = ticks(F6_DET_US);
	localparam logic [TCNT_W-1:0] F6_REC_T = ticks(F6_REC_US);
	localparam logic [TCNT_W-1:0] F47_DET_T = ticks(F47_DET_US);
	localparam logic [TCNT_W-1:0] F47_REC_T = ticks(F47_REC_US);
	localparam logic [TCNT_W-1:0] F3A8_DET_T = ticks(F3A8_DET_US);
	localparam logic [TCNT_W-1:0] F3A8_REC_T = ticks(F3A8_REC_US);
	localparam logic [TCNT_W-1:0] TXD_DIS_T = ticks(TXD_DIS_US);
	localparam logic [TCNT_W-1:0] TXD_ENA_T = ticks(TXD_ENA_US);
	localparam logic [TCNT_W-1:0] WAKE_T = ticks(WAKE_US);
	localparam logic [TCNT_W-1:0] VB_F47_DET_T = ticks(VB_F47_DET_US);
	localparam logic [TCNT_W-1:0] VB_F47_REC_T = ticks(VB_F47_REC_US);
	localparam logic [TCNT_W-1:0] VB_F3_DET_T = ticks(VB_F3_DET_US);
	localparam logic [TCNT_W-1:0] VB_F3_REC_T = ticks(VB_F3_REC_US);
	localparam logic [TCNT_W-1:0] VB_F3A8_DET_T = ticks(VB_F3A8_DET_US);
	localparam logic [TCNT_W-1:0] VB_F3A8_REC_T = ticks(VB_F3A8_REC_US);

	// Edge count comparison
	localparam int ECNT_W = 4;
	localparam logic [ECNT_W-1:0] ECD_DETECT = 4'h3;
	localparam logic [ECNT_W-1:0] ECD_RECOVER = 4'h3;
	localparam logic [ECNT_W-1:0] ECNT_MAX = 4'hf;

	// Status event word
	localparam int EVT_W = 8;
	localparam int FIFO_DEPTH = 16;
	localparam int EVT_WARN = 0;
	localparam int EVT_F125 = 1;
	localparam int EVT_F3 = 2;
	localparam int EVT_F47 = 3;
	localparam int EVT_F3A8 = 4;
	localparam int EVT_F6 = 5;
	localparam int EVT_TXCUT = 6;
	localparam int EVT_WAKE = 7;

	typedef enum logic [1:0] {
		FTCP_TX_IDLE = 2'b00,
		FTCP_TX_DOM = 2'b01,
		FTCP_TX_OFF = 2'b11,
		FTCP_TX_REARM = 2'b10
	} ftcp_txs_t;

	typedef struct packed {
		logic flag;
		logic [TCNT_W-1:0] cnt;
	} ftcp_tmr_t;
endpackage

/* core/ftcp_top.sv */
// Functional notes
// - Low transmit input drives bus dominant
// - Receive output low while bus dominant
// - Edge count difference flags failures 1,2,5
// - Edge count recovery clears failures 1,2,5
// - Long dominant transmit input disables driver
// - Recessive transmit input re-enables cut driver
// - Failure 3 flagged after detection time
// - Failure 3 cleared after recovery time
// - Failure 6 flagged after detection time
// - Failure 6 cleared after recovery time
// - Failures 4,7 flagged after detection time
// - Failures 4,7 cleared after recovery time
// - Failures 3a,8 flagged after detection time
// - Failures 3a,8 cleared after recovery time
// - Wake-up on long dominant CANH or CANL
// - Battery termination timing for failures 4,7
// - Battery termination timing for failure 3
// - Battery termination timing for failures 3a,8
// - Reset output low only in reset
// - Regulator undervoltage forces reset
// - Temperature warning flag and regulator shutdown
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module ftcp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0] wr;
		logic [AW:0] rd;
	} ftcp_fifo_t;

	ftcp_fifo_t s_reg;
	ftcp_fifo_t s_next;
	logic full;
	logic empty;

	assign empty = s_reg.wr == s_reg.rd;
	assign full = (s_reg.wr[AW-1:0] == s_reg.rd[AW-1:0]) && (s_reg.wr[AW] != s_reg.rd[AW]);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = s_reg.mem[s_reg.rd[AW-1:0]];

	always_comb
	begin
		s_next = s_reg;
		if (in_valid && !full)
		begin
			s_next.mem[s_reg.wr[AW-1:0]] = in_data;
			s_next.wr = s_reg.wr + 1'b1;
		end
		if (out_ready && !empty)
			s_next.rd = s_reg.rd + 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
module ftcp_top #(
	parameter int TICK_CYCLES = ftcp_pkg::TICK_CYCLES,
	parameter int FIFO_DEPTH = ftcp_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic tx_data,
	input wire logic canh_dom,
	input wire logic canl_dom,
	input wire logic normal_mode,
	input wire logic can_active,
	input wire logic term_vbat,
	input wire logic f3_cond,
	input wire logic f3a8_cond,
	input wire logic f47_cond,
	input wire logic f6_cond,
	input wire logic reg_undervolt,
	input wire logic reg_temp_warn,
	input wire logic reg_temp_shut,
	input wire logic evt_ready,
	output logic canh_drive,
	output logic canl_drive,
	output logic rx_data,
	output logic reset_n,
	output logic temp_warn_flag,
	output logic regulator_off,
	output logic fail125_flag,
	output logic fail3_flag,
	output logic fail47_flag,
	output logic fail3a8_flag,
	output logic fail6_flag,
	output logic tx_cutoff,
	output logic wake_flag,
	output logic evt_valid,
	output logic [ftcp_pkg::EVT_W-1:0] evt_data
);
	typedef struct packed {
		logic [ftcp_pkg::PRE_W-1:0] pre;
		logic tick;
		logic canh_q;
		logic canl_q;
		logic [ftcp_pkg::ECNT_W-1:0] ecnt_h;
		logic [ftcp_pkg::ECNT_W-1:0] ecnt_l;
		logic f125;
		logic good_h;
		ftcp_pkg::ftcp_tmr_t t3;
		ftcp_pkg::ftcp_tmr_t t47;
		ftcp_pkg::ftcp_tmr_t t3a8;
		ftcp_pkg::ftcp_tmr_t t6;
		ftcp_pkg::ftcp_txs_t txs;
		logic [ftcp_pkg::TCNT_W-1:0] tx_cnt;
		logic [ftcp_pkg::TCNT_W-1:0] wake_cnt;
		logic wake;
		logic canh_drv;
		logic canl_drv;
		logic rx;
		logic rst_n;
		logic warn;
		logic roff;
		logic [ftcp_pkg::EVT_W-1:0] last_word;
		logic pend;
		logic [ftcp_pkg::EVT_W-1:0] pend_word;
		logic ev_valid;
		logic [ftcp_pkg::EVT_W-1:0] ev_data;
	} ftcp_state_t;

	ftcp_state_t s_reg;
	ftcp_state_t s_next;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [ftcp_pkg::EVT_W-1:0] fifo_out_data;

	// Persistence timer: flag follows cond after the matching delay
	function automatic ftcp_pkg::ftcp_tmr_t tmr_step(
		input ftcp_pkg::ftcp_tmr_t t,
		input logic run,
		input logic tick,
		input logic cond,
		input logic [ftcp_pkg::TCNT_W-1:0] det,
		input logic [ftcp_pkg::TCNT_W-1:0] rec
	);
		ftcp_pkg::ftcp_tmr_t r;
		logic [ftcp_pkg::TCNT_W-1:0] lim;
		r = t;
		lim = t.flag ? rec : det;
		if (!run || (cond == t.flag))
			r.cnt = '0;
		else if (tick)
		begin
			if (t.cnt + 1'b1 >= lim)
			begin
				r.flag = cond;
				r.cnt = '0;
			end
			else
				r.cnt = t.cnt + 1'b1;
		end
		return r;
	endfunction

	// Saturating edge counter increment
	function automatic logic [ftcp_pkg::ECNT_W-1:0] ecnt_inc(
		input logic [ftcp_pkg::ECNT_W-1:0] c
	);
		return (c == ftcp_pkg::ECNT_MAX) ? c : c + 1'b1;
	endfunction

	ftcp_fifo #(
		.WIDTH(ftcp_pkg::EVT_W),
		.DEPTH(FIFO_DEPTH)
	) ftcp_fifo_inst (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_valid(s_reg.pend),
		.in_ready(fifo_in_ready),
		.in_data(s_reg.pend_word),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	assign fifo_out_ready = !s_reg.ev_valid || evt_ready;

	////////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		logic edge_h;
		logic edge_l;
		logic [ftcp_pkg::ECNT_W-1:0] diff;
		logic bus_dom;
		logic drv_en;
		logic [ftcp_pkg::EVT_W-1:0] word;
		s_next = s_reg;
		edge_h = canh_dom != s_reg.canh_q;
		edge_l = canl_dom != s_reg.canl_q;
		diff = '0;
		bus_dom = 1'b0;
		drv_en = 1'b0;
		word = '0;
		s_next.canh_q = canh_dom;
		s_next.canl_q = canl_dom;

		// Shared timebase
		s_next.tick = s_reg.pre == ftcp_pkg::PRE_W'(TICK_CYCLES - 1);
		s_next.pre = s_next.tick ? '0 : s_reg.pre + 1'b1;

		// Edge count comparison between the two lines
		if (!normal_mode)
		begin
			s_next.ecnt_h = '0;
			s_next.ecnt_l = '0;
		end
		else if (!s_reg.f125)
		begin
			if (edge_h)
				s_next.ecnt_h = ecnt_inc(s_reg.ecnt_h);
			if (edge_l)
				s_next.ecnt_l = ecnt_inc(s_reg.ecnt_l);
			diff = (s_next.ecnt_h > s_next.ecnt_l) ? s_next.ecnt_h - s_next.ecnt_l
				: s_next.ecnt_l - s_next.ecnt_h;
			if (diff >= ftcp_pkg::ECD_DETECT)
			begin
				s_next.f125 = 1'b1;
				s_next.good_h = s_next.ecnt_h > s_next.ecnt_l;
				s_next.ecnt_h = '0;
				s_next.ecnt_l = '0;
			end
			else if (s_next.ecnt_h == ftcp_pkg::ECNT_MAX || s_next.ecnt_l == ftcp_pkg::ECNT_MAX)
			begin
				s_next.ecnt_h = '0;
				s_next.ecnt_l = '0;
			end
		end
		else
		begin
			// Recovery: the silent line toggles again
			if (s_reg.good_h ? edge_l : edge_h)
				s_next.ecnt_l = ecnt_inc(s_reg.ecnt_l);
			if (s_next.ecnt_l >= ftcp_pkg::ECD_RECOVER)
			begin
				s_next.f125 = 1'b0;
				s_next.ecnt_l = '0;
			end
		end

		// Failure persistence timers
		s_next.t3 = tmr_step(s_reg.t3, normal_mode, s_reg.tick, f3_cond,
			term_vbat ? ftcp_pkg::VB_F3_DET_T : ftcp_pkg::F3_DET_T,
			term_vbat ? ftcp_pkg::VB_F3_REC_T : ftcp_pkg::F3_REC_T);
		s_next.t47 = tmr_step(s_reg.t47, normal_mode, s_reg.tick, f47_cond,
			term_vbat ? ftcp_pkg::VB_F47_DET_T : ftcp_pkg::F47_DET_T,
			term_vbat ? ftcp_pkg::VB_F47_REC_T : ftcp_pkg::F47_REC_T);
		s_next.t3a8 = tmr_step(s_reg.t3a8, normal_mode, s_reg.tick, f3a8_cond,
			term_vbat ? ftcp_pkg::VB_F3A8_DET_T : ftcp_pkg::F3A8_DET_T,
			term_vbat ? ftcp_pkg::VB_F3A8_REC_T : ftcp_pkg::F3A8_REC_T);
		s_next.t6 = tmr_step(s_reg.t6, normal_mode, s_reg.tick, f6_cond,
			ftcp_pkg::F6_DET_T, ftcp_pkg::F6_REC_T);

		// Permanent dominant transmit timer
		s_next.tx_cnt = '0;
		case (s_reg.txs)
			ftcp_pkg::FTCP_TX_IDLE:
				if (!tx_data && can_active)
					s_next.txs = ftcp_pkg::FTCP_TX_DOM;
			ftcp_pkg::FTCP_TX_DOM:
				if (tx_data || !can_active)
					s_next.txs = ftcp_pkg::FTCP_TX_IDLE;
				else if (s_reg.tick && s_reg.tx_cnt + 1'b1 >= ftcp_pkg::TXD_DIS_T)
					s_next.txs = ftcp_pkg::FTCP_TX_OFF;
				else
					s_next.tx_cnt = s_reg.tick ? s_reg.tx_cnt + 1'b1 : s_reg.tx_cnt;
			ftcp_pkg::FTCP_TX_OFF:
				if (tx_data)
					s_next.txs = ftcp_pkg::FTCP_TX_REARM;
			ftcp_pkg::FTCP_TX_REARM:
				if (!tx_data)
					s_next.txs = ftcp_pkg::FTCP_TX_OFF;
				else if (s_reg.tick && s_reg.tx_cnt + 1'b1 >= ftcp_pkg::TXD_ENA_T)
					s_next.txs = ftcp_pkg::FTCP_TX_IDLE;
				else
					s_next.tx_cnt = s_reg.tick ? s_reg.tx_cnt + 1'b1 : s_reg.tx_cnt;
			default:
				s_next.txs = ftcp_pkg::FTCP_TX_IDLE;
		endcase

		// Bus wake-up outside normal mode
		if (normal_mode)
		begin
			s_next.wake = 1'b0;
			s_next.wake_cnt = '0;
		end
		else if (!(canh_dom || canl_dom))
			s_next.wake_cnt = '0;
		else if (s_reg.tick && !s_reg.wake)
		begin
			if (s_reg.wake_cnt + 1'b1 >= ftcp_pkg::WAKE_T)
				s_next.wake = 1'b1;
			else
				s_next.wake_cnt = s_reg.wake_cnt + 1'b1;
		end

		// Driver and receiver
		drv_en = can_active && (s_reg.txs == ftcp_pkg::FTCP_TX_IDLE
			|| s_reg.txs == ftcp_pkg::FTCP_TX_DOM);
		s_next.canh_drv = drv_en && !tx_data;
		s_next.canl_drv = drv_en && !tx_data;
		if (s_reg.f125)
			bus_dom = s_reg.good_h ? canh_dom : canl_dom;
		else
			bus_dom = canh_dom || canl_dom;
		s_next.rx = !bus_dom;

		// Reset and regulator supervision
		s_next.rst_n = !reg_undervolt;
		s_next.warn = reg_temp_warn;
		s_next.roff = reg_temp_shut;

		// Status change events into the buffer; a new change beats the drain
		word[ftcp_pkg::EVT_WARN] = s_reg.warn;
		word[ftcp_pkg::EVT_F125] = s_reg.f125;
		word[ftcp_pkg::EVT_F3] = s_reg.t3.flag;
		word[ftcp_pkg::EVT_F47] = s_reg.t47.flag;
		word[ftcp_pkg::EVT_F3A8] = s_reg.t3a8.flag;
		word[ftcp_pkg::EVT_F6] = s_reg.t6.flag;
		word[ftcp_pkg::EVT_TXCUT] = s_reg.txs == ftcp_pkg::FTCP_TX_OFF
			|| s_reg.txs == ftcp_pkg::FTCP_TX_REARM;
		word[ftcp_pkg::EVT_WAKE] = s_reg.wake;
		if (s_reg.pend && fifo_in_ready)
			s_next.pend = 1'b0;
		if (word != s_reg.last_word)
		begin
			s_next.last_word = word;
			s_next.pend = 1'b1;
			s_next.pend_word = word;
		end

		// Registered output stage
		if (fifo_out_ready)
		begin
			s_next.ev_valid = fifo_out_valid;
			s_next.ev_data = fifo_out_data;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			s_reg <= '0;
			s_reg.rx <= 1'b1;
		end
		else
			s_reg <= s_next;
	end

	assign canh_drive = s_reg.canh_drv;
	assign canl_drive = s_reg.canl_drv;
	assign rx_data = s_reg.rx;
	assign reset_n = s_reg.rst_n;
	assign temp_warn_flag = s_reg.warn;
	assign regulator_off = s_reg.roff;
	assign fail125_flag = s_reg.f125;
	assign fail3_flag = s_reg.t3.flag;
	assign fail47_flag = s_reg.t47.flag;
	assign fail3a8_flag = s_reg.t3a8.flag;
	assign fail6_flag = s_reg.t6.flag;
	assign tx_cutoff = s_reg.last_word[ftcp_pkg::EVT_TXCUT];
	assign wake_flag = s_reg.wake;
	assign evt_valid = s_reg.ev_valid;
	assign evt_data = s_reg.ev_data;
endmodule

/* tb/ftcp_checker.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module ftcp_checker #(
	parameter int TICK_CYCLES = 20
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic tx_data,
	input wire logic canh_dom,
	input wire logic canl_dom,
	input wire logic normal_mode,
	input wire logic can_active,
	input wire logic term_vbat,
	input wire logic f3_cond,
	input wire logic f6_cond,
	input wire logic reg_undervolt,
	input wire logic reg_temp_warn,
	input wire logic reg_temp_shut,
	input wire logic evt_ready,
	input wire logic canh_drive,
	input wire logic canl_drive,
	input wire logic rx_data,
	input wire logic reset_n,
	input wire logic temp_warn_flag,
	input wire logic regulator_off,
	input wire logic fail125_flag,
	input wire logic fail3_flag,
	input wire logic fail47_flag,
	input wire logic fail3a8_flag,
	input wire logic fail6_flag,
	input wire logic tx_cutoff,
	input wire logic wake_flag,
	input wire logic evt_valid,
	input wire logic [ftcp_pkg::EVT_W-1:0] evt_data
);
	int cx;
	int c3;
	int c6;
	int cw;

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	// Duration in cycles close to n ticks
	function automatic bit near(input int c, input int n);
		return c >= (n - 1) * TICK_CYCLES && c <= (n + 1) * TICK_CYCLES + 4;
	endfunction

	always_ff @(posedge clk)
	begin
		cx <= (!sys_rst && !tx_data && can_active) ? cx + 1 : 0;
		c3 <= (!sys_rst && normal_mode && f3_cond != fail3_flag) ? c3 + 1 : 0;
		c6 <= (!sys_rst && normal_mode && f6_cond != fail6_flag) ? c6 + 1 : 0;
		cw <= (!sys_rst && !normal_mode && (canh_dom || canl_dom)) ? cw + 1 : 0;
	end

	tx_release_a: assert property (tx_data |=> !canh_drive && !canl_drive)
		else $error("driver on with recessive input");
	tx_drive_a: assert property (can_active throughout (tx_data [*3] ##1
		(!tx_data && !tx_cutoff)) |=> canh_drive && canl_drive)
		else $error("driver off with dominant input");
	rx_dom_a: assert property ((canh_dom || canl_dom) && !fail125_flag
		|=> !rx_data || fail125_flag)
		else $error("receive high on dominant bus");
	rx_rec_a: assert property (!canh_dom && !canl_dom |=> rx_data)
		else $error("receive low on recessive bus");
	uv_reset_a: assert property (reg_undervolt |=> !reset_n)
		else $error("reset output high in undervoltage");
	reset_high_a: assert property (!reg_undervolt && !$past(sys_rst) &&
		!$past(sys_rst, 2) |=> reset_n)
		else $error("reset output low outside reset");
	temp_copy_a: assert property (1'h1 |=> temp_warn_flag == $past(reg_temp_warn)
		&& regulator_off == $past(reg_temp_shut))
		else $error("temperature outputs wrong");
	f6_time_a: assert property ($changed(fail6_flag) |-> near(c6, ftcp_pkg::F6_DET_T))
		else $error("failure 6 timing wrong");
	f3_time_a: assert property (!term_vbat && $changed(fail3_flag) |-> near(c3,
		fail3_flag ? ftcp_pkg::F3_DET_T : ftcp_pkg::F3_REC_T))
		else $error("failure 3 timing wrong");
	tx_cut_a: assert property ($rose(tx_cutoff) |-> near(cx, ftcp_pkg::TXD_DIS_T))
		else $error("dominant timeout wrong");
	wake_time_a: assert property ($rose(wake_flag) |-> near(cw, ftcp_pkg::WAKE_T))
		else $error("wake time wrong");
	flag_freeze_a: assert property (!normal_mode && !$past(normal_mode) |=>
		$stable({fail125_flag, fail3_flag, fail47_flag, fail3a8_flag, fail6_flag}))
		else $error("flag changed outside normal mode");
	evt_hold_a: assert property (evt_valid && !evt_ready |=> evt_valid && $stable(evt_data))
		else $error("event word dropped while stalled");
endmodule

bind ftcp_top ftcp_checker #(.TICK_CYCLES(TICK_CYCLES)) ftcp_checker_inst (.*);

/* tb/ftcp_bus_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module ftcp_bus_model (
	input wire logic canh_drive,
	input wire logic canl_drive,
	input wire logic remote_dom,
	input wire logic canh_open,
	input wire logic canl_open,
	output logic canh_dom,
	output logic canl_dom
);
	// Wired-or of all nodes, an open line never seen dominant
	assign canh_dom = !canh_open && (canh_drive || remote_dom);
	assign canl_dom = !canl_open && (canl_drive || remote_dom);
endmodule

/* tb/ftcp_top_bench.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module ftcp_top_bench;
	localparam int TICK = 2;
	localparam int LIM = 20000;
	localparam int DUR[16] = '{ftcp_pkg::F3_DET_T, ftcp_pkg::F3_REC_T, ftcp_pkg::F47_DET_T,
		ftcp_pkg::F47_REC_T, ftcp_pkg::F3A8_DET_T, ftcp_pkg::F3A8_REC_T, ftcp_pkg::F6_DET_T,
		ftcp_pkg::F6_REC_T, ftcp_pkg::VB_F3_DET_T, ftcp_pkg::VB_F3_REC_T, ftcp_pkg::VB_F47_DET_T,
		ftcp_pkg::VB_F47_REC_T, ftcp_pkg::VB_F3A8_DET_T, ftcp_pkg::VB_F3A8_REC_T,
		ftcp_pkg::F6_DET_T, ftcp_pkg::F6_REC_T};
	logic clk, sys_rst, tx_data, normal_mode, can_active, term_vbat, evt_ready;
	logic reg_undervolt, reg_temp_warn, reg_temp_shut, remote_dom, canh_open, canl_open;
	logic [3:0] fc;
	logic canh_dom, canl_dom, canh_drive, canl_drive, rx_data, reset_n;
	logic temp_warn_flag, regulator_off, fail125_flag, fail3_flag, fail47_flag;
	logic fail3a8_flag, fail6_flag, tx_cutoff, wake_flag, evt_valid;
	logic [7:0] evt_data;
	logic [6:0] st;
	logic [15:0] e;
	int fails, compares, n, m;

	assign st = {wake_flag, tx_cutoff, fail125_flag, fail6_flag, fail3a8_flag, fail47_flag,
		fail3_flag};

	ftcp_top #(
		.TICK_CYCLES(TICK)
	) ftcp_top_inst (
		.*,
		.f3_cond(fc[0]),
		.f47_cond(fc[1]),
		.f3a8_cond(fc[2]),
		.f6_cond(fc[3])
	);

	ftcp_bus_model ftcp_bus_model_inst (.*);

	always #25 clk = !clk;

	task automatic results;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
		compares++;
		if ((got >= lo && got <= hi) !== 1'h1)
		begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, got, lo);
		end
	endtask

	task automatic wait_for(input int i, input logic v);
		n = 0;
		while (st[i] !== v && n < LIM)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= LIM)
		begin
			fails++;
			results();
		end
	endtask

	task automatic toggle(input int t);
		repeat (t)
		begin
			@(posedge clk);
			tx_data <= !tx_data;
			repeat (3) @(posedge clk);
		end
	endtask

	function automatic logic [15:0] span(input int t, input bit hi);
		return 16'(hi ? (t + 1) * TICK + 4 : (t - 1) * TICK);
	endfunction

	initial
	begin
		clk = 1'h0;
		{sys_rst, tx_data, can_active, normal_mode, term_vbat, fc} = 9'h1c0;
		{reg_undervolt, reg_temp_warn, reg_temp_shut, evt_ready} = 4'h0;
		{remote_dom, canh_open, canl_open} = 3'h0;
		fails = 0;
		compares = 0;
		void'($urandom(57));
		repeat (10) @(posedge clk);
		sys_rst <= 1'h0;
		repeat (3) @(posedge clk);
		for (int k = 0; k < 40; k++)
		begin
			@(posedge clk);
			tx_data <= 1'($urandom);
			remote_dom <= 1'($urandom);
			{reg_undervolt, reg_temp_warn, reg_temp_shut} <= 3'($urandom);
			repeat (3) @(posedge clk);
			#1;
			e = 16'({!tx_data, !tx_data, tx_data && !remote_dom, !reg_undervolt, reg_temp_warn,
				reg_temp_shut});
			check(16'({canh_drive, canl_drive, rx_data, reset_n, temp_warn_flag, regulator_off}),
				e, e);
		end
		$display("pin test done");
		@(posedge clk);
		{tx_data, remote_dom, reg_undervolt, normal_mode} <= 4'h9;
		for (int k = 0; k < 16; k++)
		begin
			@(posedge clk);
			term_vbat <= k[3];
			fc[k[2:1]] <= !k[0];
			wait_for(k[2:1], !k[0]);
			check(16'(n), span(DUR[k], 0), span(DUR[k], 1));
		end
		$display("failure timing test done");
		m = 0;
		repeat (400)
		begin
			@(posedge clk);
			evt_ready <= 1'($urandom);
			#1;
			if (evt_valid === 1'h1 && evt_ready === 1'h1)
			begin
				m++;
				e = 16'(evt_data);
			end
		end
		check(16'(m), 16'(ftcp_pkg::FIFO_DEPTH), 16'(ftcp_pkg::FIFO_DEPTH + 2));
		check(e, 16'(reg_temp_warn), 16'(reg_temp_warn));
		check(16'(evt_valid), 16'h0, 16'h0);
		$display("event test done");
		@(posedge clk);
		evt_ready <= 1'h1;
		tx_data <= 1'h0;
		wait_for(5, 1'h1);
		check(16'(n), span(ftcp_pkg::TXD_DIS_T, 0), span(ftcp_pkg::TXD_DIS_T, 1));
		check(16'({canh_drive, canl_drive}), 16'h0, 16'h0);
		@(posedge clk);
		tx_data <= 1'h1;
		wait_for(5, 1'h0);
		check(16'(n), span(ftcp_pkg::TXD_ENA_T, 0), span(ftcp_pkg::TXD_ENA_T, 1));
		toggle(1);
		#1;
		check(16'({canh_drive, canl_drive}), 16'h3, 16'h3);
		toggle(1);
		$display("dominant timeout test done");
		canl_open <= 1'h1;
		toggle(8);
		wait_for(4, 1'h1);
		check(16'(fail125_flag), 16'h1, 16'h1);
		toggle(1);
		#1;
		check(16'(rx_data), 16'h0, 16'h0);
		toggle(1);
		@(posedge clk);
		{canh_open, canl_open} <= 2'h2;
		toggle(4);
		wait_for(4, 1'h0);
		check(16'(fail125_flag), 16'h0, 16'h0);
		@(posedge clk);
		{canh_open, normal_mode, remote_dom} <= 3'h1;
		repeat (2 + $urandom % 20) @(posedge clk);
		remote_dom <= 1'h0;
		repeat (4) @(posedge clk);
		#1;
		check(16'(wake_flag), 16'h0, 16'h0);
		@(posedge clk);
		remote_dom <= 1'h1;
		wait_for(6, 1'h1);
		check(16'(n), span(ftcp_pkg::WAKE_T, 0), span(ftcp_pkg::WAKE_T, 1));
		$display("edge and wake test done");
		results();
	end
endmodule
